// >>> src/era_alarm_status.sv
// Receive alarm detection, latched status flags and synchronizer status.
// Assumes framer inputs on i_clock; host pins asynchronous to it.
`include "era_regs.svh"
`default_nettype none

module era_alarm_status
    import era_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Framer side
    input wire era_bit_t i_rx_bit,
    input wire era_evt_t i_evt,
    input wire logic [7:0] i_ja_fill,
    input wire logic i_crc_framing_enable,
    // Host parallel port pins
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe,
    // Interrupt
    output logic o_first_interrupt_out
);

    era_port_t pin_meta_reg, pin_sync_reg;
    logic wr_n_last_reg, rd_n_last_reg;
    logic host_wr, host_rd;
    logic [7:0] alarm_flag_reg, alarm_hold_reg;
    logic [7:0] info_flag_reg, info_hold_reg;
    logic [7:0] first_interrupt_mask_reg;
    logic [7:0] alarm_evt, info_evt, alarm_clr, info_clr;
    logic [5:0] sync_search_count_reg;
    logic [7:0] sync_state;
    logic [9:0] crc_word_cnt_reg, crc_err_cnt_reg;
    logic [1:0] align_err_run_reg, sig_err_run_reg;
    logic crc_resync_criteria, align_resync_criteria, sig_mf_resync_criteria;
    logic jitter_limit_trip;
    logic ts16_bit, mf_end, nas_bit3;
    logic [1:0] ts16_zeros_reg;
    logic ts16_one_seen_reg;
    logic sig_all_ones_alarm_reg, sig_all_zeros_alarm_reg;
    logic [1:0] dmf_run_reg;
    logic distant_mf_alarm_reg;
    logic [8:0] unf_bit_cnt_reg;
    logic [1:0] unf_zeros_reg;
    logic unframed_ones_alarm_reg;
    logic [1:0] fe_run_reg;
    logic fe_last_reg;
    logic far_end_alarm_reg;
    logic [7:0] zero_run_reg, loss_win_reg, loss_ones_reg;
    logic carrier_loss_alarm_reg;

    // Two-stage synchroniser on every host pin
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pin_meta_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                              addr: 8'h00, wdata: 8'h00};
            pin_sync_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                              addr: 8'h00, wdata: 8'h00};
            wr_n_last_reg <= 1'b1;
            rd_n_last_reg <= 1'b1;
        end else begin
            pin_meta_reg <= '{cs_n: i_cs_n, rd_n: i_rd_n, wr_n: i_wr_n,
                              addr: i_addr, wdata: i_data};
            pin_sync_reg <= pin_meta_reg;
            wr_n_last_reg <= pin_sync_reg.wr_n;
            rd_n_last_reg <= pin_sync_reg.rd_n;
        end
    end

    // Act once per strobe, on its falling edge; address is settled by then
    assign host_wr = wr_n_last_reg & ~pin_sync_reg.wr_n & ~pin_sync_reg.cs_n;
    assign host_rd = rd_n_last_reg & ~pin_sync_reg.rd_n & ~pin_sync_reg.cs_n;

    // Resync criteria and jitter limit
    assign crc_resync_criteria = i_evt.crc_word & i_evt.crc_word_err &
        (crc_err_cnt_reg == `ERA_CRC_ERR_LIMIT - 10'h001);
    assign align_resync_criteria = i_evt.align_word & i_evt.align_word_err &
        (align_err_run_reg == `ERA_ALIGN_ERR_RUN - 2'h1);
    assign sig_mf_resync_criteria = i_evt.sig_mfaw & i_evt.sig_mfaw_err &
        (sig_err_run_reg == `ERA_SIG_ERR_RUN - 2'h1);
    assign jitter_limit_trip =
        (i_ja_fill >= `ERA_JA_CAPACITY - `ERA_JA_MARGIN);

    // Codeword window and error runs
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            crc_word_cnt_reg <= 10'h000;
            crc_err_cnt_reg <= 10'h000;
            align_err_run_reg <= 2'h0;
            sig_err_run_reg <= 2'h0;
        end else begin
            if (i_evt.crc_word) begin
                if (crc_word_cnt_reg == `ERA_CRC_WINDOW - 10'h001) begin
                    crc_word_cnt_reg <= 10'h000;
                    crc_err_cnt_reg <= 10'h000;
                end else begin
                    crc_word_cnt_reg <= crc_word_cnt_reg + 10'h001;
                    if (i_evt.crc_word_err && !crc_resync_criteria) begin
                        crc_err_cnt_reg <= crc_err_cnt_reg + 10'h001;
                    end
                end
            end
            if (i_evt.align_word) begin
                if (!i_evt.align_word_err || align_resync_criteria) begin
                    align_err_run_reg <= 2'h0;
                end else begin
                    align_err_run_reg <= align_err_run_reg + 2'h1;
                end
            end
            if (i_evt.sig_mfaw) begin
                if (!i_evt.sig_mfaw_err || sig_mf_resync_criteria) begin
                    sig_err_run_reg <= 2'h0;
                end else begin
                    sig_err_run_reg <= sig_err_run_reg + 2'h1;
                end
            end
        end
    end

    // CRC4 sync search counter; wraps, never saturates
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync_search_count_reg <= 6'h00;
        end else if (!i_crc_framing_enable || i_evt.crc_synced) begin
            sync_search_count_reg <= 6'h00;
        end else if (i_evt.crc_timeout) begin
            sync_search_count_reg <= sync_search_count_reg + 6'h01;
        end
    end

    // Live synchronizer state; bit 1 of the counter has no place
    assign sync_state = {sync_search_count_reg[5:2],
                         sync_search_count_reg[0],
                         i_evt.align_hunt,
                         i_evt.sig_mf_hunt,
                         i_evt.crc_mf_hunt};

    // Frame position decodes
    assign ts16_bit = i_rx_bit.valid && (i_rx_bit.ts_num == `ERA_TS_SIG);
    assign mf_end = ts16_bit && (i_rx_bit.frame_num == `ERA_LAST_FRAME) &&
                    (i_rx_bit.bit_num == `ERA_LAST_BIT);
    assign nas_bit3 = i_rx_bit.valid && i_rx_bit.frame_num[0] &&
                      (i_rx_bit.ts_num == `ERA_TS_ALIGN) &&
                      (i_rx_bit.bit_num == `ERA_FAR_END_BIT);

    // Timeslot 16 content per multiframe; runs in any signaling mode
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ts16_zeros_reg <= 2'h0;
            ts16_one_seen_reg <= 1'b0;
            sig_all_ones_alarm_reg <= 1'b0;
            sig_all_zeros_alarm_reg <= 1'b0;
        end else if (mf_end) begin
            // Verdict includes the bit closing the multiframe
            sig_all_ones_alarm_reg <= (ts16_zeros_reg +
                {1'b0, ~i_rx_bit.data} < `ERA_SIG_ONES_ZEROS) &&
                !(ts16_zeros_reg == `ERA_SIG_ONES_ZEROS);
            sig_all_zeros_alarm_reg <=
                !(ts16_one_seen_reg | i_rx_bit.data);
            ts16_zeros_reg <= 2'h0;
            ts16_one_seen_reg <= 1'b0;
        end else if (ts16_bit) begin
            if (!i_rx_bit.data && ts16_zeros_reg != `ERA_SIG_ONES_ZEROS) begin
                ts16_zeros_reg <= ts16_zeros_reg + 2'h1;
            end
            if (i_rx_bit.data) begin
                ts16_one_seen_reg <= 1'b1;
            end
        end
    end

    // Distant multiframe alarm: two agreeing multiframes to change
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            dmf_run_reg <= 2'h0;
            distant_mf_alarm_reg <= 1'b0;
        end else if (ts16_bit && i_rx_bit.frame_num == 4'h0 &&
                     i_rx_bit.bit_num == `ERA_DIST_MF_BIT) begin
            if (i_rx_bit.data == distant_mf_alarm_reg) begin
                dmf_run_reg <= 2'h0;
            end else if (dmf_run_reg == `ERA_DIST_MF_RUN - 2'h1) begin
                distant_mf_alarm_reg <= i_rx_bit.data;
                dmf_run_reg <= 2'h0;
            end else begin
                dmf_run_reg <= dmf_run_reg + 2'h1;
            end
        end
    end

    // Unframed all ones over 512-bit windows
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            unf_bit_cnt_reg <= 9'h000;
            unf_zeros_reg <= 2'h0;
            unframed_ones_alarm_reg <= 1'b0;
        end else if (i_rx_bit.valid) begin
            unf_bit_cnt_reg <= unf_bit_cnt_reg + 9'h001;
            if (unf_bit_cnt_reg == `ERA_UNF_WINDOW) begin
                unframed_ones_alarm_reg <= (unf_zeros_reg +
                    {1'b0, ~i_rx_bit.data} < `ERA_UNF_ZEROS) &&
                    !(unf_zeros_reg == `ERA_UNF_ZEROS);
                unf_zeros_reg <= 2'h0;
            end else if (!i_rx_bit.data &&
                         unf_zeros_reg != `ERA_UNF_ZEROS) begin
                unf_zeros_reg <= unf_zeros_reg + 2'h1;
            end
        end
    end

    // Far end alarm: three agreeing non-align frames to change
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fe_run_reg <= 2'h0;
            fe_last_reg <= 1'b0;
            far_end_alarm_reg <= 1'b0;
        end else if (nas_bit3) begin
            fe_last_reg <= i_rx_bit.data;
            if (i_rx_bit.data != fe_last_reg) begin
                fe_run_reg <= 2'h1;
            end else if (fe_run_reg != `ERA_FAR_END_RUN) begin
                fe_run_reg <= fe_run_reg + 2'h1;
            end
            if (i_rx_bit.data == fe_last_reg &&
                fe_run_reg == `ERA_FAR_END_RUN - 2'h1) begin
                far_end_alarm_reg <= i_rx_bit.data;
            end
        end
    end

    // Carrier loss: zero run sets, ones density window clears
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            zero_run_reg <= 8'h00;
            loss_win_reg <= 8'h00;
            loss_ones_reg <= 8'h00;
            carrier_loss_alarm_reg <= 1'b0;
        end else if (i_rx_bit.valid) begin
            if (i_rx_bit.data) begin
                zero_run_reg <= 8'h00;
            end else if (zero_run_reg != `ERA_LOSS_ZEROS) begin
                zero_run_reg <= zero_run_reg + 8'h01;
            end
            if (!carrier_loss_alarm_reg) begin
                loss_win_reg <= 8'h00;
                loss_ones_reg <= 8'h00;
                if (!i_rx_bit.data &&
                    zero_run_reg == `ERA_LOSS_ZEROS - 8'h01) begin
                    carrier_loss_alarm_reg <= 1'b1;
                end
            end else if (loss_ones_reg + {7'h00, i_rx_bit.data} >=
                         `ERA_LOSS_ONES) begin
                carrier_loss_alarm_reg <= 1'b0;
            end else if (loss_win_reg == `ERA_LOSS_WINDOW) begin
                loss_win_reg <= 8'h00;
                loss_ones_reg <= 8'h00;
            end else begin
                loss_win_reg <= loss_win_reg + 8'h01;
                loss_ones_reg <= loss_ones_reg + {7'h00, i_rx_bit.data};
            end
        end
    end

    // Set sources: alarm levels keep re-setting while present
    always_comb begin
        alarm_evt = 8'h00;
        alarm_evt[`ERA_SR_SIG_ONES] = sig_all_ones_alarm_reg;
        alarm_evt[`ERA_SR_DIST_MF] = distant_mf_alarm_reg;
        alarm_evt[`ERA_SR_SIG_ZEROS] = sig_all_zeros_alarm_reg;
        alarm_evt[`ERA_SR_RX_SLIP] = i_evt.rx_full | i_evt.rx_empty;
        alarm_evt[`ERA_SR_UNF_ONES] = unframed_ones_alarm_reg;
        alarm_evt[`ERA_SR_FAR_END] = far_end_alarm_reg;
        alarm_evt[`ERA_SR_CARRIER] = carrier_loss_alarm_reg;
        alarm_evt[`ERA_SR_SYNC_LOST] = ~i_evt.in_sync;
        info_evt = 8'h00;
        info_evt[`ERA_RI_TX_FULL] = i_evt.tx_full;
        info_evt[`ERA_RI_TX_EMPTY] = i_evt.tx_empty;
        info_evt[`ERA_RI_JA_LIMIT] = jitter_limit_trip;
        info_evt[`ERA_RI_RX_FULL] = i_evt.rx_full;
        info_evt[`ERA_RI_RX_EMPTY] = i_evt.rx_empty;
        info_evt[`ERA_RI_CRC_RC] = crc_resync_criteria;
        info_evt[`ERA_RI_ALIGN_RC] = align_resync_criteria;
        info_evt[`ERA_RI_SIG_RC] = sig_mf_resync_criteria;
    end

    // Mask write selects bits to capture and clear
    assign alarm_clr = (host_wr &&
        pin_sync_reg.addr == `ERA_ADDR_ALARM_STATUS) ?
        pin_sync_reg.wdata : 8'h00;
    assign info_clr = (host_wr && pin_sync_reg.addr == `ERA_ADDR_RX_INFO) ?
        pin_sync_reg.wdata : 8'h00;

    // Latched flags; a same-cycle event beats the clear
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            alarm_flag_reg <= `ERA_RST_BYTE;
            info_flag_reg <= `ERA_RST_BYTE;
            alarm_hold_reg <= `ERA_RST_BYTE;
            info_hold_reg <= `ERA_RST_BYTE;
        end else begin
            alarm_flag_reg <= alarm_evt | (alarm_flag_reg & ~alarm_clr);
            info_flag_reg <= info_evt | (info_flag_reg & ~info_clr);
            alarm_hold_reg <= (alarm_flag_reg & alarm_clr) |
                              (alarm_hold_reg & ~alarm_clr);
            info_hold_reg <= (info_flag_reg & info_clr) |
                             (info_hold_reg & ~info_clr);
        end
    end

    // Interrupt mask register
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            first_interrupt_mask_reg <= `ERA_RST_MASK;
        end else if (host_wr && pin_sync_reg.addr == `ERA_ADDR_INT_MASK) begin
            first_interrupt_mask_reg <= pin_sync_reg.wdata;
        end
    end

    // Interrupt level, registered to keep the pin glitch free
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_first_interrupt_out <= 1'b0;
        end else begin
            o_first_interrupt_out <=
                |(alarm_flag_reg & first_interrupt_mask_reg);
        end
    end

    // Read data, captured at the read strobe; bus driven while it lasts
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_data <= 8'h00;
            o_data_oe <= 1'b0;
        end else begin
            o_data_oe <= ~pin_sync_reg.cs_n & ~pin_sync_reg.rd_n;
            if (host_rd) begin
                if (pin_sync_reg.addr == `ERA_ADDR_ALARM_STATUS) begin
                    o_data <= alarm_hold_reg;
                end else if (pin_sync_reg.addr == `ERA_ADDR_RX_INFO) begin
                    o_data <= info_hold_reg;
                end else if (pin_sync_reg.addr == `ERA_ADDR_INT_MASK) begin
                    o_data <= first_interrupt_mask_reg;
                end else if (pin_sync_reg.addr == `ERA_ADDR_SYNC_STATE) begin
                    o_data <= sync_state;
                end else begin
                    o_data <= 8'h00;
                end
            end
        end
    end

endmodule
`default_nettype wire

// >>> src/era_pkg.sv
// Types shared by the receive alarm/status block.
// Assumes era_regs.svh supplies the numeric constants.
`default_nettype none
package era_pkg;

    // One received bit with its position in the E1 multiframe
    typedef struct packed {
        logic valid;
        logic data;
        logic [4:0] ts_num;
        logic [2:0] bit_num;
        logic [3:0] frame_num;
    } era_bit_t;

    // Event pulses and levels reported by framer and stores
    typedef struct packed {
        logic tx_full;
        logic tx_empty;
        logic rx_full;
        logic rx_empty;
        logic crc_word;
        logic crc_word_err;
        logic align_word;
        logic align_word_err;
        logic sig_mfaw;
        logic sig_mfaw_err;
        logic crc_timeout;
        logic crc_synced;
        logic in_sync;
        logic align_hunt;
        logic sig_mf_hunt;
        logic crc_mf_hunt;
    } era_evt_t;

    // Host port pins after synchronisation
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [7:0] addr;
        logic [7:0] wdata;
    } era_port_t;

endpackage
`default_nettype wire

// >>> src/era_regs.svh
// Offsets, field positions and counts for the receive alarm/status block.
// Assumes an 8-bit host port and one bit-rate strobe from the framer.
`ifndef ERA_REGS_SVH
`define ERA_REGS_SVH

// Register offsets on the parallel port
`define ERA_ADDR_ALARM_STATUS 8'h06
`define ERA_ADDR_RX_INFO 8'h08
`define ERA_ADDR_INT_MASK 8'h16
`define ERA_ADDR_SYNC_STATE 8'h1E

// Reset values
`define ERA_RST_BYTE 8'h00
`define ERA_RST_MASK 8'h00

// Alarm status bit positions
`define ERA_SR_SIG_ONES 7
`define ERA_SR_DIST_MF 6
`define ERA_SR_SIG_ZEROS 5
`define ERA_SR_RX_SLIP 4
`define ERA_SR_UNF_ONES 3
`define ERA_SR_FAR_END 2
`define ERA_SR_CARRIER 1
`define ERA_SR_SYNC_LOST 0

// Receive information bit positions
`define ERA_RI_TX_FULL 7
`define ERA_RI_TX_EMPTY 6
`define ERA_RI_JA_LIMIT 5
`define ERA_RI_RX_FULL 4
`define ERA_RI_RX_EMPTY 3
`define ERA_RI_CRC_RC 2
`define ERA_RI_ALIGN_RC 1
`define ERA_RI_SIG_RC 0

// Frame positions (bit_num 0 is bit 1 of a timeslot)
`define ERA_TS_SIG 5'h10
`define ERA_TS_ALIGN 5'h00
`define ERA_LAST_FRAME 4'hF
`define ERA_LAST_BIT 3'h7
`define ERA_DIST_MF_BIT 3'h5
`define ERA_FAR_END_BIT 3'h2

// Counts and thresholds
`define ERA_JA_CAPACITY 8'h80
`define ERA_JA_MARGIN 8'h04
`define ERA_CRC_WINDOW 10'h3E8
`define ERA_CRC_ERR_LIMIT 10'h393
`define ERA_ALIGN_ERR_RUN 2'h3
`define ERA_SIG_ERR_RUN 2'h2
`define ERA_SIG_ONES_ZEROS 2'h3
`define ERA_DIST_MF_RUN 2'h2
`define ERA_UNF_WINDOW 9'h1FF
`define ERA_UNF_ZEROS 2'h3
`define ERA_FAR_END_RUN 2'h3
`define ERA_LOSS_ZEROS 8'hFF
`define ERA_LOSS_WINDOW 8'hFE
`define ERA_LOSS_ONES 8'h20

`endif

// >>> verification/era_alarm_status_chk.sv
// Checker on the host port and interrupt of era_alarm_status.
// Assumes host strobes are held several clocks, as the bench does.
`default_nettype none
module era_chk
    import era_pkg::*;
(
    // Clock, reset and observed ports
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire era_evt_t i_evt,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_data,
    input wire logic [7:0] o_data,
    input wire logic o_data_oe,
    input wire logic o_first_interrupt_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    logic rd, wr, mask_seen_reg;
    logic [3:0] wr_age_reg;
    logic [2:0] hunt;
    // Pin-level decode, before the design's synchronisers
    assign rd = !i_cs_n && !i_rd_n;
    assign wr = !i_cs_n && !i_wr_n;
    assign hunt = {i_evt.align_hunt, i_evt.sig_mf_hunt, i_evt.crc_mf_hunt};
    // Any nonzero mask write seen; interrupt impossible before it
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst)
            mask_seen_reg <= 1'b0;
        else if (wr && i_addr == 8'h16 && i_data != 8'h00)
            mask_seen_reg <= 1'b1;
    end
    // Cycles since last write, saturating
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst)
            wr_age_reg <= 4'hF;
        else if (wr)
            wr_age_reg <= 4'h0;
        else if (wr_age_reg != 4'hF)
            wr_age_reg <= wr_age_reg + 4'h1;
    end
    oe_on_read_a: assert property (rd [*5] |-> o_data_oe)
        else $error("read enable missing");
    oe_off_idle_a: assert property (!rd [*5] |-> !o_data_oe)
        else $error("read enable stuck");
    oe_cause_a: assert property (o_data_oe |-> $past(rd, 2) ||
        $past(rd, 3) || $past(rd, 4) || $past(rd, 5))
        else $error("read enable without read");
    data_hold_a: assert property (!$stable(o_data) |-> o_data_oe)
        else $error("read data changed outside read");
    sync_live_a: assert property ($rose(o_data_oe) &&
        i_addr == 8'h1E && hunt == $past(hunt) && hunt == $past(hunt, 2)
        |-> ##1 o_data[2:0] == $past(hunt)) else $error("search bits wrong");
    unmapped_zero_a: assert property ($rose(o_data_oe) &&
        i_addr == 8'h40 |-> ##1 o_data == 8'h00) else $error("unmapped read");
    int_needs_mask_a: assert property (o_first_interrupt_out
        |-> mask_seen_reg) else $error("interrupt with all masked");
    int_clear_a: assert property ($fell(o_first_interrupt_out)
        |-> wr_age_reg <= 4'h8) else $error("interrupt fell with no write");
    cover property ($rose(o_first_interrupt_out));
    cover property ($rose(o_data_oe) && i_addr == 8'h1E);
    cover property ($rose(o_data_oe) && i_addr == 8'h06);
endmodule
bind era_alarm_status era_chk era_chk_inst (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_evt(i_evt), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n),
    .i_wr_n(i_wr_n), .i_addr(i_addr), .i_data(i_data), .o_data(o_data),
    .o_data_oe(o_data_oe), .o_first_interrupt_out(o_first_interrupt_out));
`default_nettype wire

// >>> verification/era_line_model.sv
// Line receiver model: one E1 bit per clock with its multiframe position.
// Assumes the bench picks the pattern: 0 quiet, 1 all zeros, 2 all ones.
`default_nettype none
module era_line_model
    import era_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Pattern select and stream
    input wire logic [1:0] i_mode,
    output era_bit_t o_bit
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] pos_reg;
    logic quiet;
    // Position counter: frame, timeslot, bit
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst)
            pos_reg <= 12'h000;
        else
            pos_reg <= pos_reg + 12'h001;
    end
    // Quiet: ones at bit_num 3 and 7 only, so no alarm criterion is met
    assign quiet = &pos_reg[1:0];
    assign o_bit.valid = !i_sys_rst;
    assign o_bit.data = (i_mode == 2'h0) ? quiet : (i_mode == 2'h2);
    assign o_bit.ts_num = pos_reg[7:3];
    assign o_bit.bit_num = pos_reg[2:0];
    assign o_bit.frame_num = pos_reg[11:8];
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for era_alarm_status with a line stream model.
// Assumes a host that polls status with write, read, write-back.
`default_nettype none
module testbench
    import era_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0] mode;
        logic [15:0] evt;
        logic [7:0] arg;
        logic [7:0] exp;
    } era_row_t;
    // Event rows: pattern, event pulse, register, expected flags
    localparam era_row_t rows [7] = '{'{2'h0, 16'h8000, 8'h08, 8'h80},
        '{2'h0, 16'h4000, 8'h08, 8'h40}, '{2'h0, 16'h2000, 8'h08, 8'h10},
        '{2'h0, 16'h1000, 8'h06, 8'h10}, '{2'h0, 16'h0008, 8'h06, 8'h01},
        '{2'h1, 16'h0000, 8'h06, 8'h22}, '{2'h2, 16'h0000, 8'h06, 8'hCC}};
    // Search counter steps: pulse, count, expected state byte
    localparam era_row_t steps [4] = '{'{2'h0, 16'h0020, 8'h05, 8'h1D},
        '{2'h0, 16'h0020, 8'h3B, 8'h05}, '{2'h0, 16'h0020, 8'h06, 8'h15},
        '{2'h0, 16'h0010, 8'h01, 8'h05}};
    logic clock = 1'b0, sys_rst = 1'b1, crc_en = 1'b1;
    logic cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, data_oe, int_out;
    logic [7:0] addr = 8'h00, wdata = 8'h00, ja_fill = 8'h00, data, got;
    logic [1:0] mode = 2'h0;
    era_evt_t evt = 16'h0008;
    era_bit_t line;
    int n_errors = 0, comparisons = 0, cycles = 0;
    era_line_model era_line_model_inst (.i_clock(clock), .i_sys_rst(sys_rst),
        .i_mode(mode), .o_bit(line));
    era_alarm_status era_alarm_status_inst (.i_clock(clock),
        .i_sys_rst(sys_rst), .i_rx_bit(line), .i_evt(evt), .i_ja_fill(ja_fill),
        .i_crc_framing_enable(crc_en), .i_cs_n(cs_n), .i_rd_n(rd_n),
        .i_wr_n(wr_n), .i_addr(addr), .i_data(wdata), .o_data(data),
        .o_data_oe(data_oe), .o_first_interrupt_out(int_out));
    task automatic conclude();
        if (n_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Inputs always move 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // One host strobe; held long enough for the 2-FF synchronisers
    task automatic host(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        addr = a;
        wdata = d;
        cs_n = 1'b0;
        wr_n = !w;
        rd_n = w;
        tick(4);
        for (int k = 0; k < 8 && data_oe !== 1'b1 && !w; k++)
            tick(1);
        tick(1);
        got = data;
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        tick(4);
    endtask
    task automatic poll(input logic [7:0] a, input logic [7:0] m);
        logic [7:0] v;
        host(1'b1, a, m);
        host(1'b0, a, 8'h00);
        v = got;
        host(1'b1, a, v & m);
        got = v;
    endtask
    task automatic pulse(input logic [15:0] m, input int n);
        repeat (n) begin
            evt = evt ^ m;
            tick(1);
            evt = evt ^ m;
            tick(1);
        end
    endtask
    always #5 clock = !clock;
    // Hang guard, well above the planned run length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 100000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        tick(10);
        sys_rst = 1'b0;
        tick(4);
        chk({data_oe, int_out, 6'h00} | data, 8'h00);
        host(1'b0, 8'h16, 8'h00);
        chk(got, 8'h00);
        foreach (rows[i]) begin
            mode = rows[i].mode;
            pulse(rows[i].evt, 1);
            tick(rows[i].mode == 2'h0 ? 2 : 17000);
            poll(rows[i].arg, 8'hFF);
            chk(got, rows[i].exp);
            mode = 2'h0;
            tick(rows[i].mode == 2'h0 ? 2 : 17000);
            poll(8'h06, 8'hFF);
            poll(8'h08, 8'hFF);
        end
        // Mask 0 bits hold the read value while the flag stays latched
        pulse(16'h2008, 1);
        poll(8'h06, 8'h10);
        chk(got, 8'h10);
        poll(8'h06, 8'h01);
        chk(got, 8'h01);
        pulse(16'h0800, 86);
        pulse(16'h0C00, 914);
        // Rx full from the pulse above is still latched in the info byte
        poll(8'h08, 8'hFF);
        chk(got, 8'h10);
        pulse(16'h0800, 85);
        pulse(16'h0C00, 915);
        pulse(16'h0300, 2);
        pulse(16'h00C0, 1);
        poll(8'h08, 8'hFF);
        chk(got, 8'h04);
        pulse(16'h0300, 1);
        pulse(16'h00C0, 1);
        ja_fill = 8'h7B;
        tick(2);
        poll(8'h08, 8'hFF);
        chk(got, 8'h03);
        ja_fill = 8'h7C;
        tick(2);
        ja_fill = 8'h00;
        poll(8'h08, 8'hFF);
        chk(got, 8'h20);
        evt[2:0] = 3'b101;
        foreach (steps[i]) begin
            pulse(steps[i].evt, int'(steps[i].arg));
            host(1'b1, 8'h1E, 8'hFF);
            host(1'b0, 8'h1E, 8'h00);
            chk(got, steps[i].exp);
        end
        pulse(16'h0020, 4);
        crc_en = 1'b0;
        tick(2);
        crc_en = 1'b1;
        evt[2:0] = 3'b010;
        host(1'b0, 8'h1E, 8'h00);
        chk(got, 8'h02);
        host(1'b0, 8'h40, 8'h00);
        chk(got, 8'h00);
        host(1'b1, 8'h16, 8'h02);
        pulse(16'h0008, 1);
        chk({7'h00, int_out}, 8'h00);
        host(1'b1, 8'h16, 8'h01);
        chk({7'h00, int_out}, 8'h01);
        host(1'b0, 8'h16, 8'h00);
        chk(got, 8'h01);
        poll(8'h06, 8'h01);
        chk({7'h00, int_out}, 8'h00);
        // Mid-run reset drops latched flags and the mask
        pulse(16'h2000, 1);
        sys_rst = 1'b1;
        tick(2);
        sys_rst = 1'b0;
        tick(4);
        poll(8'h08, 8'hFF);
        chk(got, 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
